//--- hdl/otf_pkg.sv
// Constants and types for the outside-of-threshold axis flag block
// Summary of operation
// - Axis flag set at/over thresholds, else cleared; latched: cleared by status read
// - Y and Z flags evaluated only when enabled
// - Polarity 1 upper, 0 lower; bits 4,2,0
// - Polarity captured when axis flag becomes set
// - Unlatched: polarity refreshed once debounce reached
// - Event active after debounce periods of outside
// - X flag bit 5 only when X enabled
package otf_pkg;

    // ****************************************
    // Register indices and byte addresses
    // ****************************************
    localparam logic [7:0] IDX_STATUS = 8'h2d;
    localparam logic [7:0] IDX_CONFIG = 8'h20;
    localparam logic [7:0] IDX_UPPER = 8'h21;
    localparam logic [7:0] IDX_LOWER = 8'h22;
    localparam logic [7:0] IDX_DEBOUNCE = 8'h23;
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
    localparam logic [7:0] ADDR_CONFIG = {IDX_CONFIG[5:0], 2'b00};
    localparam logic [7:0] ADDR_UPPER = {IDX_UPPER[5:0], 2'b00};
    localparam logic [7:0] ADDR_LOWER = {IDX_LOWER[5:0], 2'b00};
    localparam logic [7:0] ADDR_DEBOUNCE = {IDX_DEBOUNCE[5:0], 2'b00};

    // ****************************************
    // Status field positions
    // ****************************************
    localparam int BIT_EVENT_ACTIVE = 7;
    localparam int BIT_X_FLAG = 5;
    localparam int BIT_X_POL = 4;
    localparam int BIT_Y_FLAG = 3;
    localparam int BIT_Y_POL = 2;
    localparam int BIT_Z_FLAG = 1;
    localparam int BIT_Z_POL = 0;

    // ****************************************
    // Widths and values after reset
    // ****************************************
    localparam int DATA_W = 12;
    localparam int DEB_W = 8;
    localparam logic [4:0] CONFIG_RST = 5'h00;
    localparam logic [DATA_W-1:0] UPPER_RST = 12'h000;
    localparam logic [DATA_W-1:0] LOWER_RST = 12'h000;
    localparam logic [DEB_W-1:0] DEBOUNCE_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic relative;
        logic latch;
        logic x_en;
        logic y_en;
        logic z_en;
    } otf_cfg_s;

    typedef struct packed {
        logic valid;
        logic signed [DATA_W-1:0] x;
        logic signed [DATA_W-1:0] y;
        logic signed [DATA_W-1:0] z;
    } otf_sample_s;

endpackage : otf_pkg

//--- hdl/otf_axis.sv
// One axis of outside-of-threshold detection with its polarity flag
`timescale 1ns/1ps
module otf_axis
    import otf_pkg::*;
#(
    parameter int W = DATA_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Controls
    input wire logic sample_tick,
    input wire logic enable,
    input wire logic latch,
    input wire logic deb_reached,
    input wire logic clear_read,
    // Data
    input wire logic signed [W:0] value,
    input wire logic signed [W-1:0] upper,
    input wire logic signed [W-1:0] lower,
    // Results
    output logic outside_now,
    output logic flag_reg,
    output logic pol_reg
);

    logic hit_up;
    logic hit_lo;
    logic flag_next;
    logic pol_next;

    // Inclusive compares; a disabled axis never reports
    always_comb
    begin
        hit_up = value >= $signed({upper[W-1], upper});
        hit_lo = value <= $signed({lower[W-1], lower});
        outside_now = enable && (hit_up || hit_lo);
    end

    // Flag and polarity next values
    always_comb
    begin
        flag_next = flag_reg;
        pol_next = pol_reg;
        if (!latch)
        begin
            if (sample_tick)
                flag_next = outside_now;
        end
        else
        begin
            if (clear_read)
                flag_next = 1'b0;
            // Set after clear so a new event wins over the read
            if (sample_tick && outside_now)
                flag_next = 1'b1;
        end
        // Upper wins if thresholds overlap: 1 means upper side
        if (sample_tick && outside_now && !flag_reg)
            pol_next = hit_up;
        if (!latch && sample_tick && outside_now && deb_reached)
            pol_next = hit_up;
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_reg <= 1'b0;
            pol_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            pol_reg <= pol_next;
        end
    end

endmodule : otf_axis

//--- hdl/otf_top.sv
// Outside-of-threshold axis flags with its AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module otf_top
    import otf_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int DW = DEB_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Sample stream, one valid pulse per output data period
    input wire otf_sample_s sample_in,
    // Combined event
    output logic outside_event_active,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Declarations
    // ****************************************
    otf_cfg_s cfg_reg, cfg_next;
    logic [W-1:0] upper_reg, upper_next, lower_reg, lower_next;
    logic [DW-1:0] deb_reg, deb_next, cnt_reg, cnt_next;
    logic [7:0] awaddr_reg, awaddr_next, wr_addr, status;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, wr_data;
    logic [3:0] wstrb_reg, wstrb_next, wr_strb;
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic aw_have, w_have, do_write, clear_read;
    logic signed [W-1:0] ref_reg [3], ref_next [3], raw [3];
    logic signed [W:0] value [3];
    logic [2:0] axis_en, outside_now, flag, pol;
    logic ea_reg, ea_next, any_now, deb_reached;

    // ****************************************
    // Axis values
    // ****************************************
    // Relative mode compares against the previous sample
    always_comb
    begin
        raw[0] = sample_in.x;
        raw[1] = sample_in.y;
        raw[2] = sample_in.z;
        axis_en = {cfg_reg.x_en, cfg_reg.y_en, cfg_reg.z_en};
        for (int i = 0; i < 3; i++)
        begin
            ref_next[i] = sample_in.valid ? raw[i] : ref_reg[i];
            if (cfg_reg.relative)
                value[i] = $signed({raw[i][W-1], raw[i]})
                    - $signed({ref_reg[i][W-1], ref_reg[i]});
            else
                value[i] = $signed({raw[i][W-1], raw[i]});
        end
    end
    // Index 0 is X, 2 is Z, matching enable order high to low
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            otf_axis #(.W(W)) u_axis (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .sample_tick(sample_in.valid),
                .enable(axis_en[2-g]),
                .latch(cfg_reg.latch),
                .deb_reached(deb_reached),
                .clear_read(clear_read),
                .value(value[g]),
                .upper(upper_reg),
                .lower(lower_reg),
                .outside_now(outside_now[g]),
                .flag_reg(flag[g]),
                .pol_reg(pol[g])
            );
        end
    endgenerate
    // ****************************************
    // Debounce and combined event
    // ****************************************
    // Counter saturates so a long event never wraps back to idle
    always_comb
    begin
        any_now = |outside_now;
        cnt_next = cnt_reg;
        if (sample_in.valid)
        begin
            if (!any_now)
                cnt_next = '0;
            else if (cnt_reg != {DW{1'b1}})
                cnt_next = cnt_reg + 1'b1;
        end
        deb_reached = any_now && (cnt_next >= deb_reg);
        ea_next = ea_reg;
        if (!cfg_reg.latch)
        begin
            if (sample_in.valid)
                ea_next = deb_reached;
        end
        else
        begin
            if (clear_read)
                ea_next = 1'b0;
            if (sample_in.valid && deb_reached)
                ea_next = 1'b1;
        end
    end
    // Debounce state and previous samples
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_reg <= '0;
            ea_reg <= 1'b0;
            for (int i = 0; i < 3; i++)
                ref_reg[i] <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            ea_reg <= ea_next;
            for (int i = 0; i < 3; i++)
                ref_reg[i] <= ref_next[i];
        end
    end
    // Status byte layout
    always_comb
    begin
        status = '0;
        status[BIT_EVENT_ACTIVE] = ea_reg;
        status[BIT_X_FLAG] = flag[0];
        status[BIT_X_POL] = pol[0];
        status[BIT_Y_FLAG] = flag[1];
        status[BIT_Y_POL] = pol[1];
        status[BIT_Z_FLAG] = flag[2];
        status[BIT_Z_POL] = pol[2];
    end
    // Event output mirrors status bit 7
    assign outside_event_active = ea_reg;
    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data may arrive in either order; held until paired
    always_comb
    begin
        aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
        w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
        do_write = aw_have && w_have && !bvalid_reg;
        wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
        wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
        wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
        clear_read = s_axi_arvalid && s_axi_arready
            && (s_axi_araddr == ADDR_STATUS);
    end
    // Readies from state; answers straight from registers
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    // Write channel and register updates
    always_comb
    begin
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        aw_held_next = aw_have;
        w_held_next = w_have;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        cfg_next = cfg_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        deb_next = deb_reg;
        if (s_axi_awvalid && s_axi_awready)
            awaddr_next = s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            unique case (wr_addr)
                ADDR_CONFIG:
                    if (wr_strb[0])
                        cfg_next = otf_cfg_s'(wr_data[4:0]);
                ADDR_UPPER:
                begin
                    if (wr_strb[0])
                        upper_next[7:0] = wr_data[7:0];
                    if (wr_strb[1])
                        upper_next[W-1:8] = wr_data[W-1:8];
                end
                ADDR_LOWER:
                begin
                    if (wr_strb[0])
                        lower_next[7:0] = wr_data[7:0];
                    if (wr_strb[1])
                        lower_next[W-1:8] = wr_data[W-1:8];
                end
                ADDR_DEBOUNCE:
                    if (wr_strb[0])
                        deb_next = wr_data[DW-1:0];
                // Status is read-only; the write is accepted and dropped
                ADDR_STATUS: ;
                default: bresp_next = RESP_SLVERR;
            endcase
        end
    end
    // Read data are captured before the read-clear takes effect
    always_comb
    begin
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            unique case (s_axi_araddr)
                ADDR_STATUS: rdata_next[7:0] = status;
                ADDR_CONFIG: rdata_next[4:0] = cfg_reg;
                ADDR_UPPER: rdata_next[W-1:0] = upper_reg;
                ADDR_LOWER: rdata_next[W-1:0] = lower_reg;
                ADDR_DEBOUNCE: rdata_next[DW-1:0] = deb_reg;
                default: rresp_next = RESP_SLVERR;
            endcase
        end
    end
    // Bus channel and software register state
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            cfg_reg <= otf_cfg_s'(CONFIG_RST);
            upper_reg <= UPPER_RST;
            lower_reg <= LOWER_RST;
            deb_reg <= DEBOUNCE_RST;
        end
        else
        begin
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            deb_reg <= deb_next;
        end
    end
endmodule : otf_top

//--- sim/otf_props.sv
// Port assertions for the outside-threshold flag block
`timescale 1ns/1ps
module otf_props
    import otf_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int DW = DEB_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Samples and event
    input wire otf_sample_s sample_in,
    input wire logic outside_event_active,
    // Write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****
    // Checks
    // ****
    logic rd_stat_reg;
    logic rd_stat_next;
    // Remember whether the open read targets status
    always_comb
    begin
        rd_stat_next = rd_stat_reg;
        if (s_axi_arvalid && s_axi_arready)
            rd_stat_next = (s_axi_araddr == ADDR_STATUS);
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rd_stat_reg <= 1'b0;
        else
            rd_stat_reg <= rd_stat_next;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_w_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd_answer;
        s_ar_take |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read reply");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
            |=> s_axi_rresp == RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not refused");
    property p_wr_answer;
        s_w_both |=> s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no write reply");
    property p_wr_status_ok;
        s_w_both and s_axi_awaddr == ADDR_STATUS |=> s_axi_bresp == RESP_OKAY;
    endproperty
    a_wr_status_ok: assert property (p_wr_status_ok) else $error("bad resp");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write reply moved");
    property p_stat_rsvd;
        s_axi_rvalid && rd_stat_reg |-> s_axi_rdata[31:8] == 24'h0
            && !s_axi_rdata[6];
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("spare bit set");
    property p_ev_cause;
        $rose(outside_event_active) |-> $past(sample_in.valid);
    endproperty
    a_ev_cause: assert property (p_ev_cause) else $error("event off-sample");
    property p_ev_flags;
        s_axi_rvalid && rd_stat_reg && s_axi_rdata[7]
            |-> s_axi_rdata[5] || s_axi_rdata[3] || s_axi_rdata[1];
    endproperty
    a_ev_flags: assert property (p_ev_flags) else $error("event, no axis");
endmodule : otf_props

bind otf_top otf_props #(.W(W), .DW(DW)) u_otf_props (
    .clk_sys(clk_sys), .nrst(nrst), .sample_in(sample_in),
    .outside_event_active(outside_event_active),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

//--- sim/otf_top_tb.sv
// Self-checking bench for the outside-threshold flag block
`timescale 1ns/1ps
module otf_top_tb import otf_pkg::*;;
    logic clk_sys;
    logic nrst;
    otf_sample_s sample_in;
    logic ev;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp;
    logic [1:0] rresp;
    int err_total;
    int checked;

    otf_top u_otf_top (
        .clk_sys(clk_sys), .nrst(nrst), .sample_in(sample_in),
        .outside_event_active(ev),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    // 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****
    // Helpers
    // ****
    task report_and_stop;
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // A wait that ran out ends the run
    task guard(input int n);
        if (n >= 50)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : guard

    // Handshake judged at the falling edge, acted on at the next rise
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta;
        logic tw;
        logic tk;
        logic [1:0] r;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk_sys);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tk = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tk)
                break;
        end
        bready <= 1'b0;
        guard(n);
        chk(32'(r), 32'(er));
    endtask : wr

    task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        logic ta;
        logic tk;
        logic [1:0] r;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk_sys);
            ta = arvalid & arready;
            tk = rvalid;
            r = rresp;
            d = rdata;
            @(posedge clk_sys);
            if (ta)
                arvalid <= 1'b0;
            if (tk)
                break;
        end
        rready <= 1'b0;
        guard(n);
        chk(32'(r), 32'(er));
    endtask : rd

    // One sample pulse, then settle to the falling edge
    task smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(posedge clk_sys);
        sample_in <= {1'b1, x, y, z};
        @(posedge clk_sys);
        sample_in.valid <= 1'b0;
        @(negedge clk_sys);
    endtask : smp

    // Polarity is ignored where its axis flag is clear
    function automatic logic [7:0] pmask(input logic [7:0] v);
        return v & {3'b111, v[5], 1'b1, v[3], 1'b1, v[1]};
    endfunction : pmask

    task stat(input logic [7:0] e);
        logic [31:0] d;
        rd(ADDR_STATUS, RESP_OKAY, d);
        chk({d[31:8], pmask(d[7:0])}, {24'h0, e});
    endtask : stat

    // Thresholds +100 and -100 throughout
    task setup(input logic [31:0] c, input logic [31:0] db);
        wr(ADDR_CONFIG, c, RESP_OKAY);
        wr(ADDR_UPPER, 32'h064, RESP_OKAY);
        wr(ADDR_LOWER, 32'hf9c, RESP_OKAY);
        wr(ADDR_DEBOUNCE, db, RESP_OKAY);
    endtask : setup

    // ****
    // Scenarios
    // ****
    // Values after reset and the unmapped hole
    task t_reset;
        logic [31:0] d;
        rd(ADDR_CONFIG, RESP_OKAY, d);
        chk(d, 32'h0);
        rd(ADDR_DEBOUNCE, RESP_OKAY, d);
        chk(d, 32'h0);
        stat(8'h00);
        rd(8'h00, RESP_SLVERR, d);
        wr(8'h00, 32'h0, RESP_SLVERR);
    endtask : t_reset

    // Both thresholds met exactly, then both inside by one step
    task t_abs;
        logic [31:0] d;
        setup(32'h07, 32'h0);
        rd(ADDR_LOWER, RESP_OKAY, d);
        chk(d, 32'hf9c);
        smp(12'h064, 12'hf9c, 12'h063);
        chk(32'(ev), 32'h1);
        stat(8'hb8);
        smp(12'h063, 12'hf9d, 12'hf9c);
        stat(8'h82);
        smp(12'h000, 12'h000, 12'h000);
        stat(8'h00);
        smp(12'hf9c, 12'h064, 12'h064);
        stat(8'haf);
    endtask : t_abs

    // Disabled axes never flag
    task t_enable;
        setup(32'h05, 32'h0);
        smp(12'h000, 12'hf38, 12'h000);
        stat(8'h00);
        wr(ADDR_CONFIG, 32'h00, RESP_OKAY);
        smp(12'h064, 12'hf38, 12'h064);
        stat(8'h00);
    endtask : t_enable

    // Event only on the third outside sample
    task t_deb;
        setup(32'h07, 32'h3);
        for (int i = 0; i < 3; i++)
        begin
            smp(12'h064, 12'h000, 12'h000);
            chk(32'(ev), 32'(i == 2));
        end
        smp(12'h000, 12'h000, 12'h000);
        chk(32'(ev), 32'h0);
    endtask : t_deb

    // Polarity held until the debounce count is reached
    task t_pol;
        setup(32'h07, 32'h3);
        smp(12'h064, 12'h000, 12'h000);
        stat(8'h30);
        smp(12'hf9c, 12'h000, 12'h000);
        stat(8'h30);
        smp(12'hf9c, 12'h000, 12'h000);
        stat(8'ha0);
        smp(12'h000, 12'h000, 12'h000);
    endtask : t_pol

    // Sticky flags, ignored status write, clear on read
    task t_latch;
        setup(32'h0f, 32'h0);
        smp(12'h064, 12'h000, 12'h000);
        smp(12'h000, 12'h000, 12'h000);
        wr(ADDR_STATUS, 32'hff, RESP_OKAY);
        stat(8'hb0);
        stat(8'h00);
        chk(32'(ev), 32'h0);
    endtask : t_latch

    // Deltas, not raw values, in relative mode
    task t_rel;
        setup(32'h17, 32'h0);
        smp(12'h000, 12'h000, 12'h000);
        smp(12'h1f4, 12'h000, 12'h000);
        stat(8'hb0);
        smp(12'h226, 12'h000, 12'h000);
        stat(8'h00);
        smp(12'h2bc, 12'h000, 12'h000);
        stat(8'hb0);
        smp(12'h0c8, 12'h000, 12'h000);
        stat(8'ha0);
    endtask : t_rel

    // Main sequence
    initial
    begin
        err_total = 0;
        checked = 0;
        nrst = 1'b0;
        sample_in = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_abs();
        t_enable();
        t_deb();
        t_pol();
        t_latch();
        t_rel();
        report_and_stop();
    end
endmodule : otf_top_tb
